// ### logic/prx_rx_app.v
/*
  Receive application handshake: per virtual channel descriptor queues and
  payload stores, the descriptor phase and data phase toward the user logic,
  credit release pulses, and a small AHB-Lite register slave.
  Assumes the transaction layer pushes a packet's payload words before its
  descriptor, and that all user-side inputs are synchronous to hclk.
*/
`include "prx_regs.vh"
module prx_rx_app #(
  parameter NVC = 2,
  parameter DW = 136,
  parameter DAT = 64,
  parameter QAW = 2,
  parameter PAW = 6,
  parameter CW = 32
)(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire enq_valid,
  input wire [NVC-1:0] enq_vc_sel,
  input wire enq_np,
  input wire [DW-1:0] enq_desc,
  input wire [PAW:0] enq_len,
  output wire [2*NVC-1:0] enq_ready,
  input wire pay_valid,
  input wire [NVC-1:0] pay_vc_sel,
  input wire pay_np,
  input wire [DAT-1:0] pay_data,
  output wire [2*NVC-1:0] pay_ready,
  output wire [NVC-1:0] desc_req,
  output wire [NVC*DW-1:0] desc_out,
  input wire [NVC-1:0] desc_ack,
  input wire [NVC-1:0] desc_discard,
  input wire [NVC-1:0] resend_req,
  input wire [NVC-1:0] np_hold,
  output wire [NVC-1:0] data_frame,
  output wire [NVC-1:0] payload_valid,
  output wire [NVC*DAT-1:0] payload_data,
  input wire [NVC-1:0] app_wait_state,
  output wire [NVC-1:0] fc_release,
  output wire [NVC-1:0] fc_release_np,
  output wire [NVC*(PAW+1)-1:0] fc_release_len,
  output wire [NVC-1:0] ur_cpl_needed
);
  localparam LW = PAW + 1;
  localparam EW = DW + LW;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_REQ = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;
  localparam [QAW:0] QFULL = {1'b1, {QAW{1'b0}}};
  localparam [PAW:0] PFULL = {1'b1, {PAW{1'b0}}};

  reg ctrl_en_q;
  reg clr_q;
  reg [CW-1:0] rel_cnt_q;
  reg [CW-1:0] dis_cnt_q;
  wire [NVC-1:0] busy_w;
  wire [NVC-1:0] np_pend_w;
  wire [NVC-1:0] dis_w;

  genvar v, c;
  generate
    for (v = 0; v < NVC; v = v + 1) begin : g_vc
      // Separate queues per class let non-posted requests be held back
      // while posted and completion traffic keeps its own arrival order.
      wire [1:0] has;
      wire [2*EW-1:0] heads;
      wire [2*DAT-1:0] rdat;
      wire [1:0] pop;
      wire [1:0] rd;
      wire [1:0] skip;
      reg [2:0] st_q;
      reg cls_q;
      reg req_q;
      reg dfr_q;
      reg pv_q;
      reg infl_q;
      reg [DW-1:0] desc_q;
      reg [PAW:0] len_q;
      reg [PAW:0] iss_q;
      reg [PAW:0] ld_q;
      reg [PAW:0] xf_q;
      reg [DAT-1:0] data_q;
      reg rel_q;
      reg rel_np_q;
      reg [PAW:0] rel_len_q;
      reg ur_q;
      reg dis_q;
      reg hold_q;
      reg np_prio_q;

      for (c = 0; c < 2; c = c + 1) begin : g_cls
        reg [EW-1:0] fifo [0:(1<<QAW)-1];
        reg [QAW:0] wp_q;
        reg [QAW:0] rp_q;
        reg [PAW:0] pwp_q;
        reg [PAW:0] prp_q;
        reg rdy_q;
        reg prdy_q;
        wire push = enq_valid && enq_vc_sel[v] && ((c == 1) ? enq_np : !enq_np) && rdy_q;
        wire pwr = pay_valid && pay_vc_sel[v] && ((c == 1) ? pay_np : !pay_np) && prdy_q;
        wire [QAW:0] wp_n = wp_q + {{QAW{1'b0}}, push};
        wire [QAW:0] rp_n = rp_q + {{QAW{1'b0}}, pop[c]};
        wire [PAW:0] pwp_n = pwp_q + {{PAW{1'b0}}, pwr};
        wire [PAW:0] prp_n = prp_q + {{PAW{1'b0}}, rd[c]} + (skip[c] ? len_q : {LW{1'b0}});

        always @(posedge hclk) begin
          if (push) begin
            fifo[wp_q[QAW-1:0]] <= {enq_desc, enq_len};
          end
        end

        always @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            wp_q <= {(QAW+1){1'b0}};
            rp_q <= {(QAW+1){1'b0}};
            pwp_q <= {LW{1'b0}};
            prp_q <= {LW{1'b0}};
            rdy_q <= 1'b0;
            prdy_q <= 1'b0;
          end else begin
            wp_q <= wp_n;
            rp_q <= rp_n;
            pwp_q <= pwp_n;
            prp_q <= prp_n;
            rdy_q <= (wp_n - rp_n) != QFULL;
            prdy_q <= (pwp_n - prp_n) != PFULL;
          end
        end

        prx_pay_mem #(
          .W(DAT),
          .AW(PAW)
        ) u_mem (
          .clk(hclk),
          .rst_n(hresetn),
          .wr_en(pwr),
          .wr_addr(pwp_q[PAW-1:0]),
          .wr_data(pay_data),
          .rd_en(rd[c]),
          .rd_addr(prp_q[PAW-1:0]),
          .rd_data(rdat[c*DAT +: DAT])
        );

        assign has[c] = wp_q != rp_q;
        assign heads[c*EW +: EW] = fifo[rp_q[QAW-1:0]];
        assign enq_ready[2*v+c] = rdy_q;
        assign pay_ready[2*v+c] = prdy_q;
      end

      wire pick_np = has[1] && !np_hold[v] && (np_prio_q || !has[0]);
      wire pick = ctrl_en_q && (pick_np || has[0]);
      wire [EW-1:0] head = pick_np ? heads[EW +: EW] : heads[0 +: EW];
      wire in_req = st_q == ST_REQ;
      wire in_data = st_q == ST_DATA;
      wire acc = in_req && desc_ack[v];
      wire drop = in_req && !desc_ack[v] && desc_discard[v];
      wire xfer = pv_q && !app_wait_state[v];
      wire load = in_data && infl_q && (!pv_q || xfer);
      wire last_x = xf_q == len_q - {{PAW{1'b0}}, 1'b1};
      wire issue = (acc && (len_q != {LW{1'b0}})) ||
                   (in_data && (iss_q != len_q) && (!infl_q || load));
      wire fin = (acc && (len_q == {LW{1'b0}})) || drop || (in_data && xfer && last_x);

      assign pop = {fin && cls_q, fin && !cls_q};
      assign rd = {issue && cls_q, issue && !cls_q};
      assign skip = {drop && cls_q, drop && !cls_q};

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          st_q <= ST_IDLE;
          cls_q <= 1'b0;
          req_q <= 1'b0;
          dfr_q <= 1'b0;
          pv_q <= 1'b0;
          infl_q <= 1'b0;
          desc_q <= {DW{1'b0}};
          len_q <= {LW{1'b0}};
          iss_q <= {LW{1'b0}};
          ld_q <= {LW{1'b0}};
          xf_q <= {LW{1'b0}};
          data_q <= {DAT{1'b0}};
        end else begin
          case (st_q)
            ST_IDLE: begin
              if (pick) begin
                st_q <= ST_REQ;
                cls_q <= pick_np;
                desc_q <= head[EW-1:LW];
                len_q <= head[LW-1:0];
                req_q <= 1'b1;
                dfr_q <= head[LW-1:0] != {LW{1'b0}};
              end
            end
            ST_REQ: begin
              // Descriptor registers only change on entering this state.
              if (desc_ack[v]) begin
                req_q <= 1'b0;
                if (len_q != {LW{1'b0}}) begin
                  st_q <= ST_DATA;
                  iss_q <= {{PAW{1'b0}}, 1'b1};
                  infl_q <= 1'b1;
                  ld_q <= {LW{1'b0}};
                  xf_q <= {LW{1'b0}};
                end else begin
                  st_q <= ST_IDLE;
                end
              end else if (desc_discard[v]) begin
                req_q <= 1'b0;
                dfr_q <= 1'b0;
                st_q <= ST_IDLE;
              end else if (resend_req[v]) begin
                // The entry stays queued; if it is non-posted, the hold input then keeps it back.
                req_q <= 1'b0;
                dfr_q <= 1'b0;
                st_q <= ST_IDLE;
              end
            end
            ST_DATA: begin
              iss_q <= iss_q + {{PAW{1'b0}}, issue};
              infl_q <= issue || (infl_q && !load);
              if (load) begin
                pv_q <= 1'b1;
                data_q <= rdat[cls_q*DAT +: DAT];
                ld_q <= ld_q + {{PAW{1'b0}}, 1'b1};
                if (ld_q == len_q - {{PAW{1'b0}}, 1'b1}) begin
                  dfr_q <= 1'b0;
                end
              end else if (xfer) begin
                pv_q <= 1'b0;
              end
              if (xfer) begin
                xf_q <= xf_q + {{PAW{1'b0}}, 1'b1};
                if (last_x) begin
                  st_q <= ST_IDLE;
                end
              end
            end
            default: begin
              st_q <= ST_IDLE;
            end
          endcase
        end
      end

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rel_q <= 1'b0;
          rel_np_q <= 1'b0;
          rel_len_q <= {LW{1'b0}};
          ur_q <= 1'b0;
          dis_q <= 1'b0;
          hold_q <= 1'b0;
          np_prio_q <= 1'b0;
        end else begin
          rel_q <= fin;
          rel_np_q <= cls_q;
          rel_len_q <= len_q;
          ur_q <= drop && cls_q;
          dis_q <= drop;
          hold_q <= np_hold[v];
          // A hold release in the same cycle as the queue empties still wins.
          if (hold_q && !np_hold[v]) begin
            np_prio_q <= 1'b1;
          end else if (!has[1]) begin
            np_prio_q <= 1'b0;
          end
        end
      end

      assign desc_req[v] = req_q;
      assign desc_out[v*DW +: DW] = desc_q;
      assign data_frame[v] = dfr_q;
      assign payload_valid[v] = pv_q;
      assign payload_data[v*DAT +: DAT] = data_q;
      assign fc_release[v] = rel_q;
      assign fc_release_np[v] = rel_np_q;
      assign fc_release_len[v*LW +: LW] = rel_len_q;
      assign ur_cpl_needed[v] = ur_q;
      assign busy_w[v] = !st_q[0];
      assign np_pend_w[v] = has[1];
      assign dis_w[v] = dis_q;
    end
  endgenerate

  // Register slave: zero wait states, OKAY always, unmapped reads return zero.
  reg aph_vld_q;
  reg aph_wr_q;
  reg [7:0] aph_addr_q;
  reg [31:0] rd_mux;
  reg [CW-1:0] rel_sum;
  reg [CW-1:0] dis_sum;
  integer i;
  wire aph = hsel && htrans[`PRX_HTRANS_ACTIVE] && hready;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      `PRX_ADDR_CTRL: rd_mux[`PRX_CTRL_EN] = ctrl_en_q;
      `PRX_ADDR_STAT: begin
        rd_mux[`PRX_STAT_BUSY_LSB +: NVC] = busy_w;
        rd_mux[`PRX_STAT_NP_LSB +: NVC] = np_pend_w;
        rd_mux[`PRX_STAT_HOLD_LSB +: NVC] = np_hold;
      end
      `PRX_ADDR_RELCNT: rd_mux = rel_cnt_q;
      `PRX_ADDR_DISCNT: rd_mux = dis_cnt_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @* begin
    rel_sum = rel_cnt_q;
    dis_sum = dis_cnt_q;
    for (i = 0; i < NVC; i = i + 1) begin
      rel_sum = rel_sum + {{(CW-1){1'b0}}, fc_release[i]};
      dis_sum = dis_sum + {{(CW-1){1'b0}}, dis_w[i]};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      aph_vld_q <= 1'b0;
      aph_wr_q <= 1'b0;
      aph_addr_q <= 8'h00;
      ctrl_en_q <= `PRX_CTRL_EN_RESET;
      clr_q <= 1'b0;
      rel_cnt_q <= {CW{1'b0}};
      dis_cnt_q <= {CW{1'b0}};
    end else begin
      aph_vld_q <= aph;
      if (aph) begin
        aph_wr_q <= hwrite;
        aph_addr_q <= haddr[7:0];
        hrdata <= hwrite ? 32'h0000_0000 : rd_mux;
      end
      clr_q <= 1'b0;
      if (aph_vld_q && aph_wr_q && (aph_addr_q == `PRX_ADDR_CTRL)) begin
        ctrl_en_q <= hwdata[`PRX_CTRL_EN];
        clr_q <= hwdata[`PRX_CTRL_CLR];
      end
      // Discards are counted apart from any error statistic.
      rel_cnt_q <= clr_q ? {CW{1'b0}} : rel_sum;
      dis_cnt_q <= clr_q ? {CW{1'b0}} : dis_sum;
    end
  end
endmodule // prx_rx_app

// ### pkg/prx_regs.vh
/*
  Constants for the receive application handshake block: register byte
  offsets, control and status field positions, reset values and bus codes.
  Assumes it is included by bare name from the design files.
*/
`ifndef PRX_REGS_VH
`define PRX_REGS_VH

`define PRX_ADDR_CTRL 8'h00
`define PRX_ADDR_STAT 8'h04
`define PRX_ADDR_RELCNT 8'h08
`define PRX_ADDR_DISCNT 8'h0c

`define PRX_CTRL_EN 0
`define PRX_CTRL_CLR 1
`define PRX_CTRL_EN_RESET 1'b1

`define PRX_STAT_BUSY_LSB 0
`define PRX_STAT_NP_LSB 8
`define PRX_STAT_HOLD_LSB 16

`define PRX_HTRANS_ACTIVE 1

`define PRX_CLK_MHZ 200

`endif

// ### logic/prx_pay_mem.v
/*
  Payload word store for one traffic class of one virtual channel.
  Simple dual port; read data come out of a register one cycle after rd_en
  and hold until the next read. Assumes a single clock shared by both ports.
*/
module prx_pay_mem #(
  parameter W = 64,
  parameter AW = 6
)(
  input wire clk,
  input wire rst_n,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [W-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [W-1:0] rd_data
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= {W{1'b0}};
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // prx_pay_mem

// ### dv/prx_rx_app_properties.sv
/*
  Checker for the receive application handshake, watching channel 0.
  Assumes it is bound to prx_rx_app and sees only that module's ports.
*/
module prx_rx_app_props #(
  parameter NVC = 2,
  parameter DW = 136,
  parameter PAW = 6
)(
  input wire hclk,
  input wire hresetn,
  input wire [NVC-1:0] desc_req,
  input wire [NVC*DW-1:0] desc_out,
  input wire [NVC-1:0] desc_ack,
  input wire [NVC-1:0] desc_discard,
  input wire [NVC-1:0] resend_req,
  input wire [NVC-1:0] np_hold,
  input wire [NVC-1:0] data_frame,
  input wire [NVC-1:0] payload_valid,
  input wire [NVC-1:0] app_wait_state,
  input wire [NVC-1:0] fc_release,
  input wire [NVC-1:0] fc_release_np,
  input wire [NVC*(PAW+1)-1:0] fc_release_len,
  input wire [NVC-1:0] ur_cpl_needed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Channel 0 stands for all; the engines are copies, so this keeps the checker small.
  wire rsp = desc_ack[0] | desc_discard[0] | resend_req[0];
  a_req_stable: assert property (
    desc_req[0] && !rsp |=> desc_req[0] && $stable(desc_out[DW-1:0]))
    else $error("request or descriptor moved while waiting");
  a_req_drop: assert property (
    desc_req[0] && rsp |=> !desc_req[0])
    else $error("request stayed up after an answer");
  a_frame_cause: assert property (
    $rose(data_frame[0]) |-> desc_req[0])
    else $error("framing rose without a request");
  a_pv_first: assert property (
    $rose(desc_req[0]) |-> !payload_valid[0])
    else $error("payload valid together with the request");
  a_pv_after_ack: assert property (
    desc_req[0] && desc_ack[0] && data_frame[0] |=> !payload_valid[0] ##1 payload_valid[0])
    else $error("first word not two cycles after accept");
  a_rel_no_pay: assert property (
    desc_req[0] && desc_ack[0] && !data_frame[0] |=> fc_release[0] && fc_release_len[PAW:0] == 0)
    else $error("no credit release after a bare accept");
  a_disc_drop: assert property (
    desc_req[0] && desc_discard[0] && !desc_ack[0]
      |=> fc_release[0] && !data_frame[0] && !payload_valid[0])
    else $error("discard not finished in one cycle");
  a_ur_np: assert property (
    ur_cpl_needed[0] |-> fc_release[0] && fc_release_np[0])
    else $error("completion flag without a non-posted release");
  a_rel_quiet: assert property (
    fc_release[0] |-> !payload_valid[0])
    else $error("credits released while data still moves");
  a_frame_last: assert property (
    payload_valid[0] && !app_wait_state[0] && data_frame[0] |=> !fc_release[0])
    else $error("framing still high on the last word");
  cover property (desc_req[0] && desc_discard[0]);
  cover property (ur_cpl_needed[0]);
  cover property ($fell(np_hold[0]));
endmodule // prx_rx_app_props
bind prx_rx_app prx_rx_app_props #(.NVC(NVC), .DW(DW), .PAW(PAW)) u_props (.*);

// ### dv/prx_app_model.sv
/*
  Model of the user logic on one channel: answers requests after a set delay,
  throttles the data phase and counts the words it takes.
  Assumes the same clock and reset as the block.
*/
module prx_app_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic pv,
  input wire logic [1:0] cmd,
  input wire logic [3:0] dly,
  input wire logic ws_en,
  output logic ack,
  output logic disc,
  output logic rsnd,
  output logic ws,
  output logic np_stop,
  output logic cpl_abort,
  output logic [15:0] words
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic busy_q;
  logic rs_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {ack, disc, rsnd, ws, np_stop, cpl_abort, busy_q, rs_q} <= 8'h00;
      cnt_q <= 4'h0;
      words <= 16'h0000;
    end else begin
      ack <= 1'b0;
      disc <= 1'b0;
      rsnd <= 1'b0;
      np_stop <= 1'b0;
      cpl_abort <= disc;
      ws <= ws_en & ~ws;
      if (pv && !ws) begin
        words <= words + 16'h0001;
      end
      // One answer per request, never in its first cycle; a resend is asked once.
      if (!req) begin
        busy_q <= 1'b0;
        cnt_q <= 4'h0;
      end else if (!busy_q) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q + 4'h1 >= dly) begin
          busy_q <= 1'b1;
          ack <= cmd == 2'h0 || (cmd == 2'h2 && rs_q);
          disc <= cmd == 2'h1;
          rsnd <= cmd == 2'h2 && !rs_q;
          // The hold goes up with the resend and drops once the retry may come.
          np_stop <= cmd == 2'h2 && !rs_q;
          rs_q <= cmd == 2'h2 && !rs_q;
        end
      end
    end
  end
endmodule // prx_app_model

// ### dv/testbench.sv
/*
  Self-checking bench for prx_rx_app: table of packets, then register,
  hold, ordering and channel independence tests.
  Assumes prx_app_model stands in for the user logic on each channel.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int vc; int np; int len; int cmd; int dly; int ws;} prx_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = '0;
  logic enq_valid = 1'b0, enq_np = 1'b0, pay_valid = 1'b0, pay_np = 1'b0;
  logic [1:0] enq_vc_sel = '0, pay_vc_sel = '0, hold = '0, wsen = '0;
  logic [135:0] enq_desc = '0;
  logic [6:0] enq_len = '0;
  logic [63:0] pay_data = '0;
  logic [1:0] cmd [2] = '{2'h0, 2'h0};
  logic [3:0] dly [2] = '{4'h1, 4'h1};
  wire hreadyout, hresp;
  wire [31:0] hrdata;
  wire [1:0] desc_req, data_frame, payload_valid, fc_release, fc_release_np, ack, disc, rsnd, ws;
  wire [13:0] fc_release_len;
  wire [1:0] np_stop;
  wire [3:0] erdy, prdy;
  wire [127:0] pdata;
  int widx [2] = '{0, 0};
  wire [15:0] words [2];
  int err_count = 0, samples_checked = 0, cyc = 0, w0;
  logic [31:0] r;
  prx_row_t rows [7] = '{'{0, 0, 2, 0, 1, 0}, '{0, 0, 0, 0, 3, 0}, '{1, 1, 0, 1, 1, 0},
    '{1, 0, 5, 0, 2, 1}, '{0, 1, 3, 1, 1, 0}, '{0, 0, 64, 0, 1, 1}, '{1, 1, 1, 2, 1, 0}};
  prx_rx_app uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .enq_valid(enq_valid), .enq_vc_sel(enq_vc_sel),
    .enq_np(enq_np), .enq_desc(enq_desc), .enq_len(enq_len), .enq_ready(erdy),
    .pay_valid(pay_valid), .pay_vc_sel(pay_vc_sel), .pay_np(pay_np), .pay_data(pay_data),
    .pay_ready(prdy),
    .desc_req(desc_req), .desc_out(), .desc_ack(ack), .desc_discard(disc), .resend_req(rsnd),
    .np_hold(hold | np_stop), .data_frame(data_frame), .payload_valid(payload_valid),
    .payload_data(pdata),
    .app_wait_state(ws), .fc_release(fc_release), .fc_release_np(fc_release_np),
    .fc_release_len(fc_release_len), .ur_cpl_needed());
  for (genvar v = 0; v < 2; v++) begin : g_app
    prx_app_model m (.clk(hclk), .rst_n(hresetn), .req(desc_req[v]), .pv(payload_valid[v]),
      .cmd(cmd[v]), .dly(dly[v]), .ws_en(wsen[v]), .ack(ack[v]), .disc(disc[v]),
      .rsnd(rsnd[v]), .ws(ws[v]), .np_stop(np_stop[v]), .cpl_abort(), .words(words[v]));
  end
  always #2.5 hclk = ~hclk;
  task automatic stop_test;
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test;
    end
  end
  // Every pushed word carries its index in the packet, so each taken word is checked.
  always @(posedge hclk) begin
    for (int v = 0; v < 2; v++) begin
      if (payload_valid[v] === 1'b1 && ws[v] === 1'b0) begin
        chk("payload_data", widx[v], pdata[v*64 +: 32]);
        widx[v]++;
      end
      if (fc_release[v] === 1'b1) widx[v] = 0;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk("register", e, r);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // Words go in before the descriptor, since the engine may start at once.
  task automatic push(input int vc, input int np, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge hclk);
      pay_valid <= 1'b1;
      pay_vc_sel <= 2'(1 << vc);
      pay_np <= np[0];
      pay_data <= 64'(i);
    end
    @(posedge hclk);
    pay_valid <= 1'b0;
    enq_valid <= 1'b1;
    enq_vc_sel <= 2'(1 << vc);
    enq_np <= np[0];
    enq_len <= 7'(len);
    enq_desc <= 136'(len + 16 * vc);
    @(posedge hclk);
    enq_valid <= 1'b0;
  endtask
  task automatic rel(input int vc, input int np, input int len, input int wexp);
    int n;
    n = 0;
    @(negedge hclk);
    while (fc_release[vc] !== 1'b1 && n < 300) begin
      @(negedge hclk);
      n++;
    end
    chk("fc_release", 1, fc_release[vc]);
    chk("fc_release_np", np, fc_release_np[vc]);
    chk("fc_release_len", len, fc_release_len[vc*7 +: 7]);
    chk("words", wexp, words[vc] - w0);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(8'h00, 32'h1);
    foreach (rows[k]) begin
      cmd[rows[k].vc] <= 2'(rows[k].cmd);
      dly[rows[k].vc] <= 4'(rows[k].dly);
      wsen[rows[k].vc] <= rows[k].ws[0];
      w0 = words[rows[k].vc];
      push(rows[k].vc, rows[k].np, rows[k].len);
      rel(rows[k].vc, rows[k].np, rows[k].len, rows[k].cmd == 1 ? 0 : rows[k].len);
    end
    rd(8'h08, 32'h7);
    rd(8'h0c, 32'h2);
    rd(8'h10, 32'h0);
    ahb(1'b1, 8'h00, 32'h3);
    rd(8'h08, 32'h0);
    cmd[0] <= 2'h0;
    wsen[0] <= 1'b0;
    ahb(1'b1, 8'h00, 32'h0);
    hold[0] <= 1'b1;
    w0 = words[0];
    push(0, 1, 0);
    push(0, 0, 0);
    ahb(1'b1, 8'h00, 32'h1);
    rel(0, 0, 0, 0);
    repeat (10) @(negedge hclk);
    chk("desc_req", 0, desc_req[0]);
    rd(8'h04, 32'h0001_0100);
    ahb(1'b1, 8'h00, 32'h0);
    push(0, 0, 0);
    hold[0] <= 1'b0;
    ahb(1'b1, 8'h00, 32'h1);
    rel(0, 1, 0, 0);
    rel(0, 0, 0, 0);
    dly[1] <= 4'hf;
    cmd[1] <= 2'h0;
    push(1, 0, 0);
    push(0, 0, 1);
    rel(0, 0, 1, 1);
    chk("desc_req", 1, desc_req[1]);
    w0 = words[1];
    rel(1, 0, 0, 0);
    rd(8'h08, 32'h5);
    ahb(1'b1, 8'h00, 32'h0);
    rd(8'h00, 32'h0);
    // A second reset in mid-run must bring back the idle outputs and register values.
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(negedge hclk);
    chk("reset_outputs", 32'h0, {16'h0, desc_req, data_frame, payload_valid, fc_release, erdy, prdy});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(negedge hclk);
    chk("ready", 32'hff, {24'h0, erdy, prdy});
    rd(8'h00, 32'h1);
    rd(8'h08, 32'h0);
    stop_test;
  end
endmodule // testbench
